// *** hdl/fault_pkg.sv ***
// shared constants for the fault supervision block
package fault_pkg;
   // ************************************************
   // trip causes and fault log codes
   // ************************************************
   localparam logic [1:0] CAUSE_OC          = 2'h0;
   localparam logic [1:0] CAUSE_OV          = 2'h1;
   localparam logic [1:0] CAUSE_UV          = 2'h2;
   localparam logic [1:0] CAUSE_THERMAL     = 2'h3;
   localparam logic [7:0] OC_TRIP_CODE      = 8'h01;
   localparam logic [7:0] OV_TRIP_CODE      = 8'h07;
   localparam logic [7:0] UV_TRIP_CODE      = 8'h09;
   localparam logic [7:0] THERMAL_TRIP_CODE = 8'h05;

   // ************************************************
   // retry limits
   // ************************************************
   localparam logic [1:0] OC_RETRY_LIMIT    = 2'h3;
   localparam logic [1:0] OV_RETRY_LIMIT    = 2'h3;
   localparam logic [4:0] UV_RETRY_LIMIT    = 5'h10;

   // ************************************************
   // restart methods and thermal curves
   // ************************************************
   localparam logic [1:0] RESTART_ALARM     = 2'h0;
   localparam logic [1:0] RESTART_ZERO      = 2'h1;
   localparam logic [1:0] RESTART_MATCH     = 2'h2;
   localparam logic [1:0] RESTART_MATCH_STOP = 2'h3;
   localparam logic       CURVE_REDUCED     = 1'b0;
   localparam logic       CURVE_CONSTANT    = 1'b1;

   // ************************************************
   // timing: settings count in tenths of a second
   // ************************************************
   localparam int         CLK_PERIOD_PS     = 5000;
   localparam int         TENTH_US          = 100000;
   localparam int         TENTH_CYCLES      = TENTH_US * (1000000 / CLK_PERIOD_PS);
   localparam logic [7:0] UV_WINDOW_MIN     = 8'h03;
   localparam logic [7:0] UV_WINDOW_MAX     = 8'hfa;
   localparam logic [7:0] UV_WINDOW_RESET   = 8'h0a;
   localparam logic [9:0] RETRY_WAIT_MIN    = 10'h003;
   localparam logic [9:0] RETRY_WAIT_MAX    = 10'h3e8;
   localparam logic [9:0] RETRY_WAIT_RESET  = 10'h00a;

   // ************************************************
   // thermal threshold scaling in percent, heat limit, curve shift and cooling step
   // ************************************************
   localparam int         LEVEL_MIN_PCT     = 50;
   localparam int         LEVEL_MAX_PCT     = 120;
   localparam int         TRIP_PCT          = 115;
   localparam int         HEAT_LIMIT        = 32'h0100_0000;
   localparam int         REDUCED_SHIFT     = 1;
   localparam int         COOL_STEP         = 1;
endpackage : fault_pkg

// *** hdl/thermal_accum.sv ***
// inverse-time heat accumulator for electronic thermal overload
module thermal_accum
   import fault_pkg::*;
#(
   parameter int CUR_W = 12,
   parameter int HEAT_W = 32,
   parameter int HEAT_MAX = HEAT_LIMIT
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // current samples
   input  wire logic [CUR_W-1:0]  i_meas,
   input  wire logic              i_valid,
   // settings of the active motor
   input  wire logic [CUR_W-1:0]  level,
   input  wire logic              curve_sel,
   input  wire logic [CUR_W-1:0]  rated_current,
   // result
   output logic                   therm_trip
);
   // ************************************************
   // threshold clamp and trip point
   // ************************************************
   localparam int PW = CUR_W + 8;
   logic [PW-1:0]     level_lo;
   logic [PW-1:0]     level_hi;
   logic [PW-1:0]     level_w;
   logic [PW-1:0]     level_c;
   logic [PW-1:0]     trip_pt;
   logic [PW-1:0]     cur_w;
   logic [PW-1:0]     excess;
   logic [HEAT_W-1:0] gain;
   logic              sat;
   logic [HEAT_W-1:0] heat;
   logic [HEAT_W-1:0] next_heat;

   assign level_w  = PW'(level);
   assign cur_w    = PW'(i_meas);
   // clamp keeps the setting inside its accepted range [R11]
   assign level_lo = PW'(rated_current) * PW'(LEVEL_MIN_PCT) / PW'(100);
   assign level_hi = PW'(rated_current) * PW'(LEVEL_MAX_PCT) / PW'(100);
   assign level_c  = (level_w < level_lo) ? level_lo : ((level_w > level_hi) ? level_hi : level_w); // [R11]
   // protection acts at 115 percent of the set level [R17]
   assign trip_pt  = level_c * PW'(TRIP_PCT) / PW'(100);
   assign excess   = (cur_w > trip_pt) ? (cur_w - trip_pt) : '0;
   // reduced-torque curve heats faster: fan cooling falls at low speed [R15]
   assign gain     = (curve_sel == CURVE_REDUCED) ? (HEAT_W'(excess) << REDUCED_SHIFT) : HEAT_W'(excess);
   // heat grows with overcurrent, so trip time falls inversely [R12]
   // a gain above the limit would wrap the subtraction, so test it first
   assign sat       = (gain >= HEAT_W'(HEAT_MAX)) || (heat > HEAT_W'(HEAT_MAX) - gain);
   assign next_heat = (excess != '0) ? (sat ? HEAT_W'(HEAT_MAX) : heat + gain)
                    : ((heat > HEAT_W'(COOL_STEP)) ? heat - HEAT_W'(COOL_STEP) : '0);

   // ************************************************
   // accumulator
   // ************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         heat       <= '0;
         therm_trip <= 1'b0;
      end
      else if (i_valid)
      begin
         heat       <= next_heat;
         therm_trip <= (next_heat >= HEAT_W'(HEAT_MAX)); // [R12]
      end
   end

   // ************************************************
   // checks
   // ************************************************
   a_heat_trip_point : assert property (@(posedge mclk) disable iff (!rst_n)
      i_valid && next_heat >= HEAT_W'(HEAT_MAX) |=> therm_trip) // [R12]
      else $error("thermal trip missed at limit");
endmodule : thermal_accum

// *** hdl/fault_restart_thermal_trip.sv ***
// fault supervision: automatic restart and electronic thermal trip
// Contract
// R1 - over-current trip: at most 3 restarts
// R2 - over-voltage trip: at most 3 restarts
// R3 - under-voltage trip: up to 16 restarts
// R4 - limit reached: halt until power-on reset
// R5 - method 00: alarm, no restart
// R6 - method 01: restart from zero frequency
// R7 - method 02: match speed, then resume
// R8 - method 03: match, resume, decelerate, show trip
// R9 - under-voltage beyond window trips regardless; under-voltage during MATCH or DECEL is ignored
// R10 - wait retry delay after under-voltage clears
// R11 - thermal threshold clamped 50 to 120 percent
// R12 - inverse-time heat accumulation trips at limit
// R13 - thermal trip logs code five
// R14 - any trip disables output drive immediately; under-voltage during MATCH or DECEL leaves drive_en on
// R15 - curve select: 00 reduced, 01 constant
// R16 - second motor has own level, curve
// R17 - protection acts at 115 percent level
// R18 - per-cause retry counters, cleared by reset only
// R19 - timers count tenths from prescaled clock
module fault_restart_thermal_trip
   import fault_pkg::*;
#(
   parameter int CUR_W = 12,
   parameter int TENTH_CNT = TENTH_CYCLES,
   parameter int HEAT_MAX = HEAT_LIMIT
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // fault pins from the power stage
   input  wire logic             oc_pin,
   input  wire logic             ov_pin,
   input  wire logic             uv_pin,
   // current samples
   input  wire logic [CUR_W-1:0] i_meas,
   input  wire logic             i_valid,
   input  wire logic [CUR_W-1:0] rated_current,
   // operator settings
   input  wire logic [1:0]       restart_mode,
   input  wire logic [7:0]       uv_window,
   input  wire logic [9:0]       retry_wait,
   input  wire logic [CUR_W-1:0] thermal_level_m1,
   input  wire logic             thermal_curve_sel_m1,
   input  wire logic [CUR_W-1:0] thermal_level_m2,
   input  wire logic             thermal_curve_sel_m2,
   input  wire logic             motor2_sel,
   // speed matching and stop handshakes
   input  wire logic             match_done,
   input  wire logic             stop_done,
   // drive control
   output logic                  drive_en,
   output logic                  restart_zero,
   output logic                  match_req,
   output logic                  decel_req,
   output logic                  alarm,
   output logic                  halted,
   // fault history
   output logic                  log_we,
   output logic [7:0]            log_code,
   // retry counters
   output logic [1:0]            oc_count,
   output logic [1:0]            ov_count,
   output logic [4:0]            uv_count
);
   // ************************************************
   // types and signals
   // ************************************************
   typedef enum logic [2:0] {RUN, UV_RIDE, WAIT, MATCH, DECEL, ALARM, HALT} state_t;
   localparam int TW = $clog2(TENTH_CNT + 1);

   state_t        state;
   logic [2:0]    sync_a;
   logic [2:0]    sync_b;
   logic          oc_s;
   logic          ov_s;
   logic          uv_s;
   logic [TW-1:0] pre;
   logic          tick;
   logic [9:0]    timer;
   logic          therm_trip;
   logic          active;
   logic          trip_evt;
   logic [1:0]    trip_cause;
   logic [7:0]    trip_code;
   logic          can_retry;
   logic          uv_expired;
   logic          wait_done;
   logic [7:0]    uv_win_c;
   logic [9:0]    wait_c;
   logic [CUR_W-1:0] level_act;
   logic          curve_act;

   // ************************************************
   // pin synchronisers
   // ************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {uv_pin, ov_pin, oc_pin};
         sync_b <= sync_a;
      end
   end
   assign oc_s = sync_b[0];
   assign ov_s = sync_b[1];
   assign uv_s = sync_b[2];

   // ************************************************
   // tenth-second prescaler
   // ************************************************
   assign tick = (pre == TW'(TENTH_CNT - 1)); // [R19]
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pre <= '0;
      else
         pre <= tick ? '0 : pre + 1'b1; // [R19]
   end

   // ************************************************
   // thermal overload, settings of the active motor
   // ************************************************
   assign level_act = motor2_sel ? thermal_level_m2 : thermal_level_m1; // [R16]
   assign curve_act = motor2_sel ? thermal_curve_sel_m2 : thermal_curve_sel_m1; // [R16] [R15]

   thermal_accum #(
      .CUR_W         (CUR_W),
      .HEAT_W        (32),
      .HEAT_MAX      (HEAT_MAX)
   ) u_thermal (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .i_meas        (i_meas),
      .i_valid       (i_valid),
      .level         (level_act),
      .curve_sel     (curve_act),
      .rated_current (rated_current),
      .therm_trip    (therm_trip)
   );

   // ************************************************
   // trip decode
   // ************************************************
   // out-of-range settings are clamped rather than rejected
   assign uv_win_c   = (uv_window < UV_WINDOW_MIN) ? UV_WINDOW_MIN
                     : ((uv_window > UV_WINDOW_MAX) ? UV_WINDOW_MAX : uv_window);
   assign wait_c     = (retry_wait < RETRY_WAIT_MIN) ? RETRY_WAIT_MIN
                     : ((retry_wait > RETRY_WAIT_MAX) ? RETRY_WAIT_MAX : retry_wait);
   assign active     = (state == RUN) || (state == MATCH) || (state == DECEL);
   assign trip_evt   = active && (oc_s || ov_s || therm_trip);
   // over-current wins: it is the one that damages the bridge fastest
   assign trip_cause = oc_s ? CAUSE_OC : (ov_s ? CAUSE_OV : CAUSE_THERMAL);
   assign trip_code  = oc_s ? OC_TRIP_CODE : (ov_s ? OV_TRIP_CODE : THERMAL_TRIP_CODE); // [R13]
   assign can_retry  = (trip_cause == CAUSE_OC) ? (oc_count < OC_RETRY_LIMIT) // [R1]
                     : ((trip_cause == CAUSE_OV) ? (ov_count < OV_RETRY_LIMIT) : 1'b0); // [R2]
   assign uv_expired = tick && (timer >= 10'(uv_win_c)); // [R9]
   assign wait_done  = tick && (timer >= wait_c); // [R10]

   // ************************************************
   // restart sequencer
   // ************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= RUN;
         timer        <= '0;
         drive_en     <= 1'b1;
         restart_zero <= 1'b0;
         match_req    <= 1'b0;
         decel_req    <= 1'b0;
         alarm        <= 1'b0;
         halted       <= 1'b0;
         log_we       <= 1'b0;
         log_code     <= '0;
         oc_count     <= '0;
         ov_count     <= '0;
         uv_count     <= '0;
      end
      else
      begin
         log_we       <= 1'b0;
         restart_zero <= 1'b0;
         if (tick)
            timer <= timer + 1'b1; // [R19]
         if (trip_evt)
         begin
            drive_en  <= 1'b0; // [R14]
            match_req <= 1'b0;
            decel_req <= 1'b0;
            log_we    <= 1'b1; // [R13]
            log_code  <= trip_code;
            timer     <= '0;
            if (restart_mode == RESTART_ALARM || trip_cause == CAUSE_THERMAL)
            begin
               state <= ALARM; // [R5]
               alarm <= 1'b1;
            end
            else if (!can_retry)
            begin
               state  <= HALT; // [R4]
               alarm  <= 1'b1;
               halted <= 1'b1;
            end
            else
            begin
               state <= WAIT;
               if (trip_cause == CAUSE_OC)
                  oc_count <= oc_count + 1'b1; // [R18] [R1]
               else
                  ov_count <= ov_count + 1'b1; // [R18] [R2]
            end
         end
         else
         begin
            case (state)
               RUN:
               begin
                  if (uv_s)
                  begin
                     state    <= UV_RIDE;
                     drive_en <= 1'b0; // [R14]
                     timer    <= '0;
                  end
               end
               UV_RIDE:
               begin
                  if (uv_expired)
                  begin
                     state    <= ALARM; // [R9]
                     alarm    <= 1'b1;
                     log_we   <= 1'b1;
                     log_code <= UV_TRIP_CODE;
                  end
                  else if (!uv_s)
                  begin
                     timer <= '0;
                     if (restart_mode == RESTART_ALARM)
                     begin
                        state <= ALARM; // [R5]
                        alarm <= 1'b1;
                     end
                     else if (uv_count >= UV_RETRY_LIMIT)
                     begin
                        state  <= HALT; // [R3] [R4]
                        alarm  <= 1'b1;
                        halted <= 1'b1;
                     end
                     else
                     begin
                        state    <= WAIT;
                        uv_count <= uv_count + 1'b1; // [R18] [R3]
                     end
                  end
               end
               WAIT:
               begin
                  if (uv_s)
                  begin
                     state <= UV_RIDE;
                     timer <= '0;
                  end
                  else if (wait_done)
                  begin
                     drive_en <= 1'b1; // [R10]
                     if (restart_mode == RESTART_ZERO)
                     begin
                        state        <= RUN;
                        restart_zero <= 1'b1; // [R6]
                     end
                     else
                     begin
                        state     <= MATCH; // [R7] [R8]
                        match_req <= 1'b1;
                     end
                  end
               end
               MATCH:
               begin
                  if (match_done)
                  begin
                     match_req <= 1'b0;
                     if (restart_mode == RESTART_MATCH_STOP)
                     begin
                        state     <= DECEL; // [R8]
                        decel_req <= 1'b1;
                     end
                     else
                        state <= RUN; // [R7]
                  end
               end
               DECEL:
               begin
                  if (stop_done)
                  begin
                     state     <= ALARM; // [R8]
                     decel_req <= 1'b0;
                     drive_en  <= 1'b0;
                     alarm     <= 1'b1;
                  end
               end
               ALARM, HALT:
                  state <= state; // [R4]
               default:
                  state <= HALT;
            endcase
         end
      end
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_trip_mode0;
      trip_evt && restart_mode == RESTART_ALARM;
   endsequence
   sequence s_alarm_off;
      alarm && !drive_en && !restart_zero;
   endsequence

   a_oc_retry_bound : assert property (trip_evt && oc_s && restart_mode != RESTART_ALARM // [R1]
      && oc_count == OC_RETRY_LIMIT |=> state == HALT && halted && oc_count == OC_RETRY_LIMIT)
      else $error("over-current retries above limit");
   a_ov_retry_grow : assert property (ov_count >= $past(ov_count)) // [R2] [R18]
      else $error("over-voltage counter decreased");
   a_uv_retry_bound : assert property (uv_count <= UV_RETRY_LIMIT) // [R3]
      else $error("under-voltage retries above limit");
   a_halt_stays : assert property (state == HALT |=> state == HALT && halted && !drive_en) // [R4]
      else $error("left halt without reset");
   a_mode0_alarm : assert property (s_trip_mode0 |=> s_alarm_off [*2]) // [R5]
      else $error("method zero did not alarm");
   a_zero_restart : assert property (restart_zero |-> drive_en && $past(state) == WAIT) // [R6]
      else $error("zero restart outside retry wait");
   a_uv_window_trip : assert property (state == UV_RIDE && uv_expired && !trip_evt // [R9]
      |=> state == ALARM && log_we && log_code == UV_TRIP_CODE)
      else $error("ride-through window not enforced");
   a_wait_no_drive : assert property (state == WAIT && !wait_done |=> !drive_en) // [R10]
      else $error("drive before retry delay");
   a_thermal_code : assert property (trip_evt && !oc_s && !ov_s // [R13]
      |=> log_we && log_code == THERMAL_TRIP_CODE && state == ALARM)
      else $error("thermal trip code not logged");
   a_trip_drive_off : assert property (trip_evt |=> !drive_en ##1 !drive_en) // [R14]
      else $error("drive stayed on after trip");
   a_match_then_stop : assert property (state == MATCH && match_done && !trip_evt // [R8]
      && restart_mode == RESTART_MATCH_STOP |=> decel_req && !match_req)
      else $error("method three did not decelerate");
endmodule : fault_restart_thermal_trip

// *** sim/mains_motor_model.sv ***
// mains and motor model for the fault supervision bench
module mains_motor_model
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // faults, load and pace set by the bench
   input  wire logic        fault_oc,
   input  wire logic        fault_ov,
   input  wire logic        fault_uv,
   input  wire logic [11:0] amps,
   input  wire logic        slow,
   // drive side
   input  wire logic        match_req,
   input  wire logic        decel_req,
   output logic             oc_pin,
   output logic             ov_pin,
   output logic             uv_pin,
   output logic [11:0]      i_meas,
   output logic             i_valid,
   output logic             match_done,
   output logic             stop_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] lag;
   logic [1:0] phase;
   logic [5:0] lag_end;
   assign oc_pin     = fault_oc;
   assign ov_pin     = fault_ov;
   assign uv_pin     = fault_uv;
   assign lag_end    = slow ? 6'h28 : 6'h02;
   assign match_done = match_req && (lag == lag_end);
   assign stop_done  = decel_req && (lag == lag_end);
   // ************************************************
   // current samples and spin-down answers
   // ************************************************
   // sample bus holds junk between samples, so a late read is caught
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lag     <= 6'h00;
         phase   <= 2'h0;
         i_valid <= 1'b0;
         i_meas  <= 12'h000;
      end
      else
      begin
         phase   <= phase + 2'h1;
         i_valid <= (phase == 2'h3);
         i_meas  <= (phase == 2'h3) ? amps : ~amps;
         lag     <= (match_done || stop_done || !(match_req || decel_req)) ? 6'h00 : lag + 6'h01;
      end
   end
endmodule : mains_motor_model

// *** sim/fault_restart_thermal_trip_test.sv ***
// self-checking bench for the fault supervision block
module fault_restart_thermal_trip_test;
   timeunit 1ns;
   timeprecision 100ps;
   import fault_pkg::*;
   logic        mclk, rst_n, oc_pin, ov_pin, uv_pin, i_valid, match_done, stop_done;
   logic        fault_oc, fault_ov, fault_uv, slow, curve_m1, curve_m2, motor2_sel;
   logic        drive_en, restart_zero, match_req, decel_req, alarm, halted, log_we;
   logic [1:0]  restart_mode, oc_count, ov_count;
   logic [4:0]  uv_count;
   logic [7:0]  log_code;
   logic [11:0] amps, i_meas, level_m1, level_m2;
   int          fails, n_checks;

   // short tenths and heat limit keep the run small
   fault_restart_thermal_trip #(.TENTH_CNT(10), .HEAT_MAX(64)) fault_restart_thermal_trip_i (
      .mclk(mclk), .rst_n(rst_n), .oc_pin(oc_pin), .ov_pin(ov_pin), .uv_pin(uv_pin),
      .i_meas(i_meas), .i_valid(i_valid), .rated_current(12'h3e8), .restart_mode(restart_mode),
      .uv_window(8'h03), .retry_wait(10'h003), .thermal_level_m1(level_m1),
      .thermal_curve_sel_m1(curve_m1), .thermal_level_m2(level_m2), .thermal_curve_sel_m2(curve_m2),
      .motor2_sel(motor2_sel), .match_done(match_done), .stop_done(stop_done), .drive_en(drive_en),
      .restart_zero(restart_zero), .match_req(match_req), .decel_req(decel_req), .alarm(alarm),
      .halted(halted), .log_we(log_we), .log_code(log_code), .oc_count(oc_count),
      .ov_count(ov_count), .uv_count(uv_count));
   mains_motor_model mains_motor_model_i (
      .mclk(mclk), .rst_n(rst_n), .fault_oc(fault_oc), .fault_ov(fault_ov), .fault_uv(fault_uv),
      .amps(amps), .slow(slow), .match_req(match_req), .decel_req(decel_req), .oc_pin(oc_pin),
      .ov_pin(ov_pin), .uv_pin(uv_pin), .i_meas(i_meas), .i_valid(i_valid),
      .match_done(match_done), .stop_done(stop_done));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic stop_test;
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   function automatic logic sig(input int k);
      case (k)
         0: return log_we;
         1: return drive_en;
         2: return match_req;
         3: return decel_req;
         4: return alarm;
         default: return halted;
      endcase
   endfunction : sig

   task automatic wait_sig(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v)
      begin
         cyc(1);
         n++;
         if (n > 3000)
         begin
            chk(sig(k), v);
            stop_test();
         end
      end
   endtask : wait_sig

   task automatic do_reset(input logic [1:0] mode);
      @(posedge mclk);
      #1;
      rst_n = 1'b0;
      {fault_oc, fault_ov, fault_uv, motor2_sel} = 4'h0;
      amps = 12'h000;
      restart_mode = mode;
      cyc(12);
      rst_n = 1'b1;
      cyc(1);
      chk({drive_en, alarm, halted, log_we}, 4'h8);
      chk({oc_count, ov_count, uv_count}, 9'h000);
   endtask : do_reset

   // raise one power-stage fault until the trip is logged
   task automatic pin_trip(input logic oc, input logic [7:0] code);
      fault_oc = oc;
      fault_ov = !oc;
      wait_sig(0, 1'b1);
      chk(log_code, code);
      chk(drive_en, 1'b0);
      {fault_oc, fault_ov} = 2'h0;
      cyc(1);
      chk(log_we, 1'b0);
   endtask : pin_trip

   // ************************************************
   // scenarios
   // ************************************************
   task automatic retry_limit(input logic oc, input logic [1:0] mode);
      do_reset(mode);
      for (int i = 1; i <= 3; i++)
      begin
         pin_trip(oc, oc ? OC_TRIP_CODE : OV_TRIP_CODE);
         chk(oc ? oc_count : ov_count, i);
         chk(oc ? ov_count : oc_count, 0);
         if (mode == RESTART_ZERO)
         begin
            wait_sig(1, 1'b1);
            chk(restart_zero, 1'b1);
         end
         else
         begin
            wait_sig(2, 1'b1);
            wait_sig(2, 1'b0);
            cyc(1);
            chk({drive_en, decel_req, alarm}, 3'h4);
         end
      end
      pin_trip(oc, oc ? OC_TRIP_CODE : OV_TRIP_CODE);
      cyc(200);
      chk({halted, drive_en}, 2'h2);
      chk(oc ? oc_count : ov_count, 3);
   endtask : retry_limit

   task automatic alarm_modes;
      do_reset(RESTART_ALARM);
      pin_trip(1'b0, OV_TRIP_CODE);
      cyc(200);
      chk({alarm, drive_en, ov_count}, 4'h8);
      do_reset(RESTART_MATCH_STOP);
      slow = 1'b0;
      pin_trip(1'b1, OC_TRIP_CODE);
      wait_sig(2, 1'b1);
      wait_sig(3, 1'b1);
      chk(alarm, 1'b0);
      wait_sig(4, 1'b1);
      chk(drive_en, 1'b0);
   endtask : alarm_modes

   task automatic uv_cases;
      do_reset(RESTART_ZERO);
      for (int i = 1; i <= 17; i++)
      begin
         fault_uv = 1'b1;
         cyc(12);
         chk(drive_en, 1'b0);
         fault_uv = 1'b0;
         cyc(18);
         chk(drive_en, 1'b0);
         if (i <= 16)
         begin
            wait_sig(1, 1'b1);
            chk(uv_count, i);
         end
      end
      cyc(200);
      chk({halted, drive_en, uv_count}, 7'h50);
      do_reset(RESTART_ZERO);
      fault_uv = 1'b1;
      cyc(20);
      chk(alarm, 1'b0);
      wait_sig(0, 1'b1);
      chk(log_code, UV_TRIP_CODE);
      cyc(2);
      chk({alarm, drive_en}, 2'h2);
   endtask : uv_cases

   task automatic thermal_cases;
      do_reset(RESTART_ZERO);
      // below half of rated is raised to half, trip point 575
      {level_m1, amps} = {12'h100, 12'h226};
      cyc(300);
      chk(alarm, 1'b0);
      {level_m1, level_m2, amps} = {12'h3e8, 12'h1f4, 12'h44c};
      cyc(300);
      chk({alarm, drive_en}, 2'h1);
      motor2_sel = 1'b1;
      wait_sig(0, 1'b1);
      chk(log_code, THERMAL_TRIP_CODE);
      chk(drive_en, 1'b0);
      cyc(300);
      chk({alarm, drive_en, restart_zero}, 3'h4);
      // level above 120 percent is cut to 1200: trip point 1380, excess 16
      do_reset(RESTART_ZERO);
      {level_m1, amps} = {12'hfff, 12'h574};
      cyc(12);
      chk(alarm, 1'b0);
      wait_sig(4, 1'b1);
      chk(log_code, THERMAL_TRIP_CODE);
      // reduced curve doubles heating: half the samples to trip
      do_reset(RESTART_ZERO);
      {motor2_sel, amps} = {1'b1, 12'h24f};
      cyc(12);
      chk(alarm, 1'b1);
   endtask : thermal_cases

   initial
   begin
      {rst_n, fault_oc, fault_ov, fault_uv, motor2_sel, curve_m2} = 6'h00;
      {slow, curve_m1} = 2'h3;
      {restart_mode, amps, level_m1, level_m2} = {2'h0, 12'h000, 12'h3e8, 12'h3e8};
      fails = 0;
      n_checks = 0;
      retry_limit(1'b1, RESTART_ZERO);
      retry_limit(1'b0, RESTART_MATCH);
      alarm_modes();
      uv_cases();
      thermal_cases();
      stop_test();
   end
endmodule : fault_restart_thermal_trip_test
